/* File: rtl/uial_pkg.sv */
// Package with the constants and types of the user input alarm logic.
package uial_pkg;

  // Number of contact and virtual input pairs that can be selected.
  localparam int unsigned NUM_INPUTS = 14;
  localparam int unsigned SRC_W = 4;
  localparam int unsigned SYNC_STAGES = 2;

  // Reset values of the block's state.
  localparam logic RST_ASSERTED = 1'b0;
  localparam logic RST_EVT_VALID = 1'b0;
  localparam logic [SRC_W-1:0] RST_SRC = 4'h0;

  // Source index of the last selectable pair.
  localparam logic [SRC_W-1:0] SRC_LAST = 4'hd;

  // Feature function of the user input.
  typedef enum logic [1:0] {
    UIAL_FUNC_DISABLED = 2'b00,
    UIAL_FUNC_TRIP = 2'b01,
    UIAL_FUNC_ALARM = 2'b10,
    UIAL_FUNC_CONTROL = 2'b11
  } uial_func_e;

  // Assertion modes that combine the contact and its virtual input.
  typedef enum logic [3:0] {
    UIAL_MODE_CLOSED = 4'b0000,
    UIAL_MODE_OPEN = 4'b0001,
    UIAL_MODE_VON = 4'b0010,
    UIAL_MODE_VOFF = 4'b0011,
    UIAL_MODE_CL_AND_VON = 4'b0100,
    UIAL_MODE_CL_AND_VOFF = 4'b0101,
    UIAL_MODE_OP_AND_VON = 4'b0110,
    UIAL_MODE_OP_AND_VOFF = 4'b0111,
    UIAL_MODE_CL_OR_VON = 4'b1000
  } uial_mode_e;

  // Configuration of one user input.
  typedef struct packed {
    uial_func_e func;
    uial_mode_e mode;
    logic [SRC_W-1:0] src;
    logic name_set;
  } uial_cfg_s;

  // Event recorder entry written on each assertion.
  typedef struct packed {
    uial_func_e func;
    uial_mode_e mode;
    logic [SRC_W-1:0] src;
  } uial_evt_s;

  localparam uial_evt_s RST_EVT = '{UIAL_FUNC_DISABLED, UIAL_MODE_CLOSED,
                                    4'h0};

endpackage

/* File: rtl/uial_sync.sv */
// Two-stage synchroniser for a vector of asynchronous levels.
`timescale 1ns/10ps
module uial_sync #(
  parameter int unsigned WIDTH = 14
) (
  // Clock, reset and enable.
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic ce_in,
  // Levels.
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] meta_nxt;
  logic [WIDTH-1:0] sync_r;
  logic [WIDTH-1:0] sync_nxt;

  always_comb
  begin
    meta_nxt = meta_r;
    sync_nxt = sync_r;
    if (ce_in)
    begin
      meta_nxt = async_in;
      sync_nxt = meta_r;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      meta_r <= '0;
      sync_r <= '0;
    end
    else
    begin
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
    end
  end

  assign sync_out = sync_r;

endmodule

/* File: rtl/uial_core.sv */
// Assertion logic of one user input whose function is alarm.
`timescale 1ns/10ps
module uial_core #(
  parameter int unsigned NUM_INPUTS = uial_pkg::NUM_INPUTS
) (
  // Clock, reset and enable.
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic ce_in,
  // Field contacts and operator virtual inputs, asynchronous.
  input wire logic [NUM_INPUTS-1:0] contact_closed_in,
  input wire logic [NUM_INPUTS-1:0] virtual_on_in,
  // Setpoints of this user input.
  input wire uial_pkg::uial_cfg_s cfg_in,
  // Alarm state and auxiliary output 3.
  output logic asserted_out,
  output logic aux3_led_out,
  output logic aux3_relay_out,
  // Diagnostic message.
  output logic msg_show_out,
  output logic msg_named_out,
  // Event recorder.
  output logic evt_valid_out,
  output uial_pkg::uial_evt_s evt_out
);

  // Returns whether the mode is asserted for the given operands.
  function automatic logic mode_eval(uial_pkg::uial_mode_e mode,
                                     logic closed, logic von);
    logic res;
    res = 1'b0;
    unique case (mode)
      uial_pkg::UIAL_MODE_CLOSED: res = closed;
      uial_pkg::UIAL_MODE_OPEN: res = !closed;
      uial_pkg::UIAL_MODE_VON: res = von;
      uial_pkg::UIAL_MODE_VOFF: res = !von;
      uial_pkg::UIAL_MODE_CL_AND_VON: res = closed && von;
      uial_pkg::UIAL_MODE_CL_AND_VOFF: res = closed && !von;
      uial_pkg::UIAL_MODE_OP_AND_VON: res = !closed && von;
      uial_pkg::UIAL_MODE_OP_AND_VOFF: res = !closed && !von;
      uial_pkg::UIAL_MODE_CL_OR_VON: res = closed || von;
      // Unused mode codes never assert.
      default: res = 1'b0;
    endcase
    return res;
  endfunction

  // Picks one bit of a vector; an index past the last pair reads as zero.
  function automatic logic pick(logic [NUM_INPUTS-1:0] vec,
                                logic [uial_pkg::SRC_W-1:0] idx);
    logic res;
    res = 1'b0;
    if (idx <= uial_pkg::SRC_LAST)
    begin
      res = vec[idx];
    end
    return res;
  endfunction

  logic [NUM_INPUTS-1:0] contact_sync;
  logic [NUM_INPUTS-1:0] virtual_sync;
  logic closed_sel;
  logic von_sel;
  logic cond;

  logic asserted_r;
  logic asserted_nxt;
  logic named_r;
  logic named_nxt;
  logic evt_valid_r;
  logic evt_valid_nxt;
  uial_pkg::uial_evt_s evt_r;
  uial_pkg::uial_evt_s evt_nxt;

  // Both input vectors cross into the clock domain before use.
  uial_sync #(
    .WIDTH(2 * NUM_INPUTS)
  ) u_sync (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .ce_in(ce_in),
    .async_in({contact_closed_in, virtual_on_in}),
    .sync_out({contact_sync, virtual_sync})
  );

  always_comb
  begin
    closed_sel = pick(contact_sync, cfg_in.src);
    von_sel = pick(virtual_sync, cfg_in.src);
    // Only the alarm function acts; other functions live elsewhere.
    cond = (cfg_in.func == uial_pkg::UIAL_FUNC_ALARM) &&
           mode_eval(cfg_in.mode, closed_sel, von_sel);
  end

  // The alarm state follows the condition each enabled cycle; the event entry changes only on a rise.
  always_comb
  begin
    asserted_nxt = asserted_r;
    named_nxt = named_r;
    evt_valid_nxt = evt_valid_r;
    evt_nxt = evt_r;
    if (ce_in)
    begin
      asserted_nxt = cond;
      named_nxt = cond && cfg_in.name_set;
      evt_valid_nxt = cond && !asserted_r;
      if (cond && !asserted_r)
      begin
        evt_nxt = '{cfg_in.func, cfg_in.mode, cfg_in.src};
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      asserted_r <= uial_pkg::RST_ASSERTED;
      named_r <= uial_pkg::RST_ASSERTED;
      evt_valid_r <= uial_pkg::RST_EVT_VALID;
      evt_r <= uial_pkg::RST_EVT;
    end
    else
    begin
      asserted_r <= asserted_nxt;
      named_r <= named_nxt;
      evt_valid_r <= evt_valid_nxt;
      evt_r <= evt_nxt;
    end
  end

  assign asserted_out = asserted_r;
  assign aux3_led_out = asserted_r;
  assign aux3_relay_out = asserted_r;
  assign msg_show_out = asserted_r;
  assign msg_named_out = named_r;
  // A frozen pulse is shown only while the block is enabled.
  assign evt_valid_out = evt_valid_r && ce_in;
  assign evt_out = evt_r;

  // Checking helpers: the setpoints as the evaluation saw them, and the selected contact at the pin.
  logic alarm_cfg;
  logic [uial_pkg::SRC_W-1:0] src_q;
  logic pin_closed;
  logic name_q;
  assign alarm_cfg = cfg_in.func == uial_pkg::UIAL_FUNC_ALARM;
  assign src_q = cfg_in.src;
  // The selected contact as it stands at the pin, before synchronising.
  assign pin_closed = pick(contact_closed_in, src_q);
  assign name_q = cfg_in.name_set;

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_n_in);

  sequence en_mode_s(uial_pkg::uial_mode_e m);
    ce_in && alarm_cfg && cfg_in.mode == m && $stable(cfg_in);
  endsequence

  sequence rise_s;
    !asserted_r ##1 asserted_r;
  endsequence

  closed_mode_a: assert property (
    en_mode_s(uial_pkg::UIAL_MODE_CLOSED) |=> asserted_r == $past(closed_sel))
    else $error("contact closed mode does not follow the contact");

  open_mode_a: assert property (
    en_mode_s(uial_pkg::UIAL_MODE_OPEN) |=> asserted_r == !$past(closed_sel))
    else $error("contact open mode does not follow the contact");

  von_mode_a: assert property (
    en_mode_s(uial_pkg::UIAL_MODE_VON) |=> asserted_r == $past(von_sel))
    else $error("virtual on mode does not follow the virtual input");

  voff_mode_a: assert property (
    en_mode_s(uial_pkg::UIAL_MODE_VOFF) |=> asserted_r == !$past(von_sel))
    else $error("virtual off mode does not follow the virtual input");

  and_on_mode_a: assert property (
    en_mode_s(uial_pkg::UIAL_MODE_CL_AND_VON) |=>
      asserted_r == ($past(closed_sel) && $past(von_sel)))
    else $error("closed and on mode wrong");

  and_coff_mode_a: assert property (
    en_mode_s(uial_pkg::UIAL_MODE_CL_AND_VOFF) |=>
      asserted_r == ($past(closed_sel) && !$past(von_sel)))
    else $error("closed and off mode wrong");

  and_oon_mode_a: assert property (
    en_mode_s(uial_pkg::UIAL_MODE_OP_AND_VON) |=>
      asserted_r == (!$past(closed_sel) && $past(von_sel)))
    else $error("open and on mode wrong");

  and_ooff_mode_a: assert property (
    en_mode_s(uial_pkg::UIAL_MODE_OP_AND_VOFF) |=>
      asserted_r == (!$past(closed_sel) && !$past(von_sel)))
    else $error("open and off mode wrong");

  or_mode_a: assert property (
    en_mode_s(uial_pkg::UIAL_MODE_CL_OR_VON) |=>
      asserted_r == ($past(closed_sel) || $past(von_sel)))
    else $error("closed or on mode wrong");

  single_operand_a: assert property (
    ce_in && alarm_cfg && cfg_in.mode == uial_pkg::UIAL_MODE_CL_AND_VON &&
      (closed_sel != von_sel) |=> !msg_show_out && !aux3_relay_out)
    else $error("one operand alone raised the alarm");

  not_alarm_a: assert property (
    ce_in && !alarm_cfg |=> !asserted_r && !evt_valid_r)
    else $error("alarm raised under another function");

  aux_follow_a: assert property (
    aux3_led_out == asserted_r && aux3_relay_out == asserted_r &&
      msg_show_out == asserted_r)
    else $error("auxiliary output or message off while asserted");

  event_rise_a: assert property (
    ce_in ##0 rise_s |-> evt_valid_r && evt_r.src == $past(src_q))
    else $error("assertion without event entry");

  event_once_a: assert property (
    ce_in && asserted_r && evt_valid_r ##1 ce_in |-> !evt_valid_r)
    else $error("event written twice for one assertion");

  no_latch_a: assert property (
    ce_in && !cond |=> !asserted_r ##0 !msg_show_out ##0 !aux3_led_out)
    else $error("alarm latched after the condition ended");

  source_sel_a: assert property (
    ce_in && alarm_cfg && cfg_in.mode == uial_pkg::UIAL_MODE_CLOSED &&
      src_q > uial_pkg::SRC_LAST |=> !asserted_r)
    else $error("alarm from a source outside the selectable range");

  sync_delay_a: assert property (
    (ce_in && $stable(cfg_in)) [*3] ##1
      en_mode_s(uial_pkg::UIAL_MODE_CLOSED) ##0 src_q <= uial_pkg::SRC_LAST
      |-> asserted_r == $past(pin_closed, 3))
    else $error("contact does not reach the alarm three edges later");

  freeze_a: assert property (
    !ce_in |=> $stable(asserted_r) && $stable(evt_r))
    else $error("state moved while disabled");

  reset_idle_a: assert property (
    $rose(rst_n_in) |-> !asserted_r && !msg_show_out && !aux3_relay_out)
    else $error("alarm shown straight after reset");

  raise_on_cond_a: assert property (
    ce_in && cond |=> aux3_led_out && aux3_relay_out && msg_show_out)
    else $error("condition true but alarm outputs stayed off");

  name_flag_a: assert property (
    ce_in |=> msg_named_out == ($past(cond) && $past(name_q)))
    else $error("name flag does not match the programmed name");

  no_event_fall_a: assert property (
    ce_in && !cond |=> !evt_valid_r)
    else $error("event written without an assertion");

  event_func_a: assert property (
    evt_valid_out |-> evt_out.func == uial_pkg::UIAL_FUNC_ALARM)
    else $error("event entry does not name the alarm function");

  idle_off_a: assert property (
    !asserted_r |-> !msg_show_out && !aux3_led_out && !aux3_relay_out &&
      !msg_named_out)
    else $error("message or auxiliary output on while deasserted");

  // The other AND modes must also stay quiet on one operand.
  single_mixed_a: assert property (
    ce_in && alarm_cfg && (cfg_in.mode == uial_pkg::UIAL_MODE_CL_AND_VOFF ||
      cfg_in.mode == uial_pkg::UIAL_MODE_OP_AND_VON) &&
      closed_sel == von_sel |=> !msg_show_out && !aux3_led_out)
    else $error("one operand alone raised a mixed AND mode");

  single_open_a: assert property (
    ce_in && alarm_cfg && cfg_in.mode == uial_pkg::UIAL_MODE_OP_AND_VOFF &&
      closed_sel != von_sel |=> !msg_show_out && !aux3_led_out)
    else $error("one operand alone raised the open and off mode");

  mode_refused_a: assert property (
    ce_in && cfg_in.mode > uial_pkg::UIAL_MODE_CL_OR_VON |=> !asserted_r)
    else $error("unused mode code raised the alarm");

  reset_quiet_a: assert property (
    $rose(rst_n_in) |-> !evt_valid_r && !msg_named_out && !aux3_led_out)
    else $error("event or name flag straight after reset");

endmodule

/* File: verif/uial_field.sv */
// Model of the field contacts and the operator virtual inputs.
`timescale 1ns/10ps
module uial_field (
  // Selected pair and its levels.
  input wire logic [uial_pkg::SRC_W-1:0] sel_in,
  input wire logic closed_in,
  input wire logic von_in,
  // Levels of the pairs that are not selected.
  input wire logic [uial_pkg::NUM_INPUTS-1:0] noise_c_in,
  input wire logic [uial_pkg::NUM_INPUTS-1:0] noise_v_in,
  // Levels at the device terminals.
  output logic [uial_pkg::NUM_INPUTS-1:0] contact_out,
  output logic [uial_pkg::NUM_INPUTS-1:0] virtual_out
);
  always_comb
  begin
    contact_out = noise_c_in;
    virtual_out = noise_v_in;
    // A source past the last pair selects no terminal.
    if (sel_in <= uial_pkg::SRC_LAST)
    begin
      contact_out[sel_in] = closed_in;
      virtual_out[sel_in] = von_in;
    end
  end
endmodule

/* File: verif/user_input_alarm_assert_logic_test.sv */
// Self-checking bench of the user input alarm logic.
`timescale 1ns/10ps
module user_input_alarm_assert_logic_test;
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic closed = 1'b0;
  logic von = 1'b0;
  logic exp_now = 1'b0;
  logic ce = 1'b1;
  logic [13:0] noise_c = '0;
  logic [13:0] noise_v = '0;
  logic [13:0] contact;
  logic [13:0] virt;
  logic [31:0] seed = 32'h00006ca7;
  logic [5:0] cs = 6'h22;
  logic [5:0] vs = 6'h28;
  uial_pkg::uial_cfg_s cfg = '0;
  uial_pkg::uial_cfg_s k;
  uial_pkg::uial_evt_s evt;
  uial_pkg::uial_evt_s evt_q[$];
  logic named_q[$];
  logic asserted, led, relay, msg, named, evt_valid;
  int n_fail = 0;
  int n_checks = 0;
  int cycles = 0;

  always #12.5 clk_in = ~clk_in;

  uial_field u_field (.sel_in(cfg.src), .closed_in(closed), .von_in(von),
    .noise_c_in(noise_c), .noise_v_in(noise_v), .contact_out(contact),
    .virtual_out(virt));

  uial_core u_dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .ce_in(ce),
    .contact_closed_in(contact), .virtual_on_in(virt), .cfg_in(cfg),
    .asserted_out(asserted), .aux3_led_out(led), .aux3_relay_out(relay),
    .msg_show_out(msg), .msg_named_out(named), .evt_valid_out(evt_valid),
    .evt_out(evt));

  function automatic logic [31:0] xorshift(input logic [31:0] x);
    logic [31:0] y;
    y = x ^ (x << 13);
    y = y ^ (y >> 17);
    return y ^ (y << 5);
  endfunction

  function automatic logic cond(input logic [3:0] m, input logic c,
                                input logic v);
    case (m)
      4'h0: return c;
      4'h1: return !c;
      4'h2: return v;
      4'h3: return !v;
      4'h4: return c && v;
      4'h5: return c && !v;
      4'h6: return !c && v;
      4'h7: return !c && !v;
      4'h8: return c || v;
      default: return 1'b0;
    endcase
  endfunction

  task automatic report_and_stop();
    $display("checks %0d, mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic check(input string what, input logic [15:0] e,
                       input logic [15:0] g);
    n_checks++;
    if (g !== e)
    begin
      n_fail++;
      $display("unexpected %s: expected %h, seen %h", what, e, g);
    end
  endtask

  // The setpoints, the selected levels and the noise of the other pairs all change at once in one step.
  task automatic step(input uial_pkg::uial_cfg_s nc, input logic c,
                      input logic v);
    logic e;
    @(negedge clk_in);
    seed = xorshift(seed);
    noise_c = seed[13:0];
    noise_v = seed[29:16];
    cfg = nc;
    closed = c;
    von = v;
    e = (nc.func == uial_pkg::UIAL_FUNC_ALARM) &&
        (nc.src <= uial_pkg::SRC_LAST) && cond(nc.mode, c, v);
    if (e && !exp_now)
    begin
      evt_q.push_back(uial_pkg::uial_evt_s'{nc.func, nc.mode, nc.src});
      named_q.push_back(nc.name_set);
    end
    exp_now = e;
    repeat (4) @(negedge clk_in);
    check("asserted", 16'(e), 16'(asserted));
    check("led", 16'(e), 16'(led));
    check("relay", 16'(e), 16'(relay));
    check("message", 16'(e), 16'(msg));
  endtask

  // Each event pulse is matched against the oldest expected entry.
  always @(negedge clk_in)
  begin
    cycles++;
    if (cycles > 4000)
    begin
      n_fail++;
      report_and_stop();
    end
    if (evt_valid === 1'b1)
    begin
      if (evt_q.size() == 0)
        check("extra event", 16'h0, 16'h1);
      else
      begin
        check("event entry", 16'(evt_q[0]), 16'(evt));
        check("name flag", 16'(named_q[0]), 16'(named));
        void'(evt_q.pop_front());
        void'(named_q.pop_front());
      end
    end
  end

  initial
  begin
    repeat (12) @(negedge clk_in);
    rst_n_in = 1'b1;
    @(negedge clk_in);
    check("asserted after reset", 16'h0, 16'(asserted));
    for (int m = 0; m < 9; m++)
    begin
      seed = xorshift(seed);
      k = '{uial_pkg::UIAL_FUNC_DISABLED, uial_pkg::uial_mode_e'(m[3:0]),
            4'(seed[7:0] % 14), seed[8]};
      step(k, 1'b1, 1'b1);
      k.func = uial_pkg::UIAL_FUNC_TRIP;
      step(k, 1'b1, 1'b1);
      k.func = uial_pkg::UIAL_FUNC_ALARM;
      step(k, 1'b1, 1'b1);
      for (int j = 0; j < 6; j++)
        step(k, cs[j], vs[j]);
      $display("mode %0d done", m);
    end
    @(negedge clk_in);
    rst_n_in = 1'b0;
    @(negedge clk_in);
    check("asserted in reset", 16'h0, 16'(asserted));
    check("event in reset", 16'h0, 16'(evt_valid));
    evt_q.push_back(uial_pkg::uial_evt_s'{k.func, k.mode, k.src});
    named_q.push_back(k.name_set);
    rst_n_in = 1'b1;
    @(negedge clk_in);
    check("asserted after release", 16'h0, 16'(asserted));
    repeat (4) @(negedge clk_in);
    check("asserted again", 16'h1, 16'(asserted));
    step(k, 1'b0, 1'b0);
    $display("reset test done");
    @(negedge clk_in);
    ce = 1'b0;
    closed = 1'b1;
    repeat (6) @(negedge clk_in);
    check("asserted while frozen", 16'h0, 16'(asserted));
    ce = 1'b1;
    evt_q.push_back(uial_pkg::uial_evt_s'{k.func, k.mode, k.src});
    named_q.push_back(k.name_set);
    exp_now = 1'b1;
    repeat (4) @(negedge clk_in);
    check("asserted after enable", 16'h1, 16'(asserted));
    k.src = 4'he;
    k.mode = uial_pkg::UIAL_MODE_CLOSED;
    step(k, 1'b1, 1'b1);
    k.src = 4'h3;
    k.mode = uial_pkg::uial_mode_e'(4'h9);
    step(k, 1'b1, 1'b1);
    k.func = uial_pkg::UIAL_FUNC_CONTROL;
    k.mode = uial_pkg::UIAL_MODE_CLOSED;
    step(k, 1'b1, 1'b1);
    repeat (4) @(negedge clk_in);
    check("pending events", 16'h0, 16'(evt_q.size()));
    $display("enable and refusal test done");
    report_and_stop();
  end
endmodule
